// File: hw/cis_pkg.sv
/*
  constants for the core instruction sequencer: field layout, special
  instruction codes, oscillator mode codes, phase and start-up counts.
  assumes one clk cycle equals one oscillator period.
*/
package cis_pkg;
  // instruction word layout
  localparam int INSTR_W = 14;
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int DEST_POS = 7;
  localparam int FILE_HI = 6;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int LIT8_HI = 7;
  localparam int LIT11_HI = 10;
  localparam int GOTO_POS = 11;
  // instruction classes in the top two bits
  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_JUMP = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;
  // special control words
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETFIE = 14'h0009;
  localparam logic [3:0] OP_DECFSZ = 4'hb;
  localparam logic [3:0] OP_INCFSZ = 4'hf;
  localparam logic [1:0] OP_BCLR = 2'h0;
  localparam logic [1:0] OP_BSET = 2'h1;
  localparam logic [1:0] OP_BTSTC = 2'h2;
  localparam logic [1:0] OP_BTSTS = 2'h3;
  localparam logic [1:0] OP_RETLIT = 2'h1;
  // oscillator mode select codes
  localparam logic [1:0] low_power_crystal_mode = 2'h0;
  localparam logic [1:0] standard_crystal_mode = 2'h1;
  localparam logic [1:0] high_speed_crystal_mode = 2'h2;
  localparam logic [1:0] resistor_capacitor_osc_mode = 2'h3;
  // addresses and reset values
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [1:0] PHASE_RESET = 2'h0;
  localparam int PHASES = 4;
  // start-up delay, in oscillator periods, then in clk cycles
  localparam int OST_TOSC = 1024;
  localparam int CLK_PER_TOSC = 1;
  localparam int OST_CYCLES = OST_TOSC * CLK_PER_TOSC;
  localparam int OST_W = 11;
  // sequencer states, gray code in listed order: run, flush, sleep, wait, dummies
  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_FLUSH = 3'h1,
    ST_SLEEP = 3'h3,
    ST_OST = 3'h2,
    ST_DUMMY1 = 3'h6,
    ST_DUMMY2 = 3'h7
  } cis_state_t;
endpackage : cis_pkg

// File: hw/cis_quarter.sv
/*
  quarter phase generator: four clk periods form one instruction cycle.
  assumes a free-running oscillator clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_quarter
  import cis_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // phases
  output logic [3:0] QUARTER,
  output logic LAST
);
  logic [1:0] phase;
  logic [1:0] next_phase;

  always_comb begin
    next_phase = phase + 2'h1; // see RULE_07
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      phase <= PHASE_RESET;
    end else begin
      phase <= next_phase;
    end
  end

  assign QUARTER = 4'h1 << phase; // see RULE_07
  assign LAST = (phase == 2'(PHASES - 1));
endmodule : cis_quarter
`default_nettype wire

// File: hw/cis_sequencer.sv
/*
  instruction decode and cycle sequencing for an 8-bit core with 14-bit
  instruction words. assumes program memory answers combinationally to PC,
  and that the datapath gives the skip condition and stack top at phase 4.
*/
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE_01: take 14-bit words, opcode plus operands
// RULE_02: dest bit 0 writes W, 1 writes file
// RULE_03: file operand is 7-bit address 0x00-0x7f
// RULE_04: bit operand picks bit of file register
// RULE_05: literal operand is eight or eleven bits
// RULE_06: one cycle; skip or jump adds nop cycle
// RULE_07: cycle is four oscillator periods in order
// RULE_08: crystal wake waits 1024 periods, resistor-capacitor none
// RULE_09: wake branches to 0004h only if enabled
// RULE_10: two bits pick mode; external clock only high-speed
// RULE_11: wake runs next instruction, two dummies, vector
// RULE_12: flushed cycle changes no state
module cis_sequencer
  import cis_pkg::*;
#(
  parameter int PC_W = 13
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // program memory
  output logic [PC_W-1:0] PC,
  input wire logic [INSTR_W-1:0] INSTR,
  // configuration and interrupt
  input wire logic OSC_MODE_SEL_HI,
  input wire logic OSC_MODE_SEL_LO,
  input wire logic GLOBAL_IRQ_ENABLE,
  input wire logic IRQ_WAKE,
  // datapath feedback
  input wire logic COND_TRUE,
  input wire logic [PC_W-1:0] STACK_TOP,
  input wire logic [1:0] PC_PAGE,
  // decoded fields
  output logic [1:0] OP_CLASS,
  output logic [6:0] FILE_ADDR,
  output logic [2:0] BIT_SEL,
  output logic [7:0] LITERAL8,
  output logic [10:0] LITERAL11,
  // commit strobes
  output logic [3:0] QUARTER,
  output logic EXEC_VALID,
  output logic WR_W,
  output logic WR_FILE,
  output logic PUSH,
  output logic POP,
  output logic SLEEPING,
  output logic EXT_CLK_OK
);
  if (PC_W < 13) begin : g_pc_w_check
    $error("PC_W must hold page and 11-bit literal");
  end

  cis_state_t state;
  cis_state_t next_state;
  logic [INSTR_W-1:0] ir;
  logic [INSTR_W-1:0] next_ir;
  logic [PC_W-1:0] next_pc;
  logic irq_pend;
  logic next_irq_pend;
  logic [OST_W-1:0] ost_cnt;
  logic [OST_W-1:0] next_ost_cnt;
  logic last;
  logic [1:0] osc_mode;
  logic crystal;
  logic [1:0] cls;
  logic is_goto;
  logic is_call;
  logic is_ret;
  logic is_skip;
  logic is_sleep;
  logic run;

  cis_quarter u_quarter (
    .CLK(CLK),
    .RST_N(RST_N),
    .QUARTER(QUARTER),
    .LAST(last)
  );

  assign osc_mode = {OSC_MODE_SEL_HI, OSC_MODE_SEL_LO}; // see RULE_10
  assign crystal = (osc_mode != resistor_capacitor_osc_mode);
  assign EXT_CLK_OK = (osc_mode == high_speed_crystal_mode); // see RULE_10

  // field split of the executing word
  assign cls = ir[CLS_HI:CLS_LO]; // see RULE_01
  assign OP_CLASS = cls;
  assign FILE_ADDR = ir[FILE_HI:0]; // see RULE_03
  assign BIT_SEL = ir[BIT_HI:BIT_LO]; // see RULE_04
  assign LITERAL8 = ir[LIT8_HI:0]; // see RULE_05
  assign LITERAL11 = ir[LIT11_HI:0]; // see RULE_05

  assign is_goto = (cls == CLS_JUMP);
  assign is_call = is_goto && !ir[GOTO_POS];
  assign is_ret = (ir == OP_RETURN) || (ir == OP_RETFIE)
    || (cls == CLS_LIT && ir[11:10] == OP_RETLIT);
  assign is_skip = (cls == CLS_BYTE
      && (ir[11:8] == OP_DECFSZ || ir[11:8] == OP_INCFSZ))
    || (cls == CLS_BIT && (ir[11:10] == OP_BTSTC || ir[11:10] == OP_BTSTS));
  assign is_sleep = (ir == OP_SLEEP);

  // only the run state commits; flush, dummy and sleep do nothing
  assign run = (state == ST_RUN);
  assign EXEC_VALID = run; // see RULE_12
  assign SLEEPING = (state == ST_SLEEP) || (state == ST_OST);

  always_comb begin
    WR_W = 1'b0;
    WR_FILE = 1'b0;
    if (run && last) begin
      if (cls == CLS_BYTE && ir[13:8] != 6'h0) begin
        WR_W = !ir[DEST_POS]; // see RULE_02
        WR_FILE = ir[DEST_POS]; // see RULE_02
      end else if (cls == CLS_BYTE) begin
        WR_FILE = ir[DEST_POS]; // see RULE_02
      end else if (cls == CLS_BIT) begin
        WR_FILE = (ir[11:10] == OP_BCLR) || (ir[11:10] == OP_BSET);
      end else if (cls == CLS_LIT) begin
        WR_W = 1'b1;
      end
    end
  end

  assign PUSH = last && ((run && is_call) || (run && irq_pend)); // see RULE_11
  assign POP = last && run && is_ret && !irq_pend;

  always_comb begin
    next_state = state;
    next_ir = ir;
    next_pc = PC;
    next_irq_pend = irq_pend;
    next_ost_cnt = ost_cnt;
    if (state == ST_OST) begin
      if (ost_cnt != OST_W'(OST_CYCLES)) begin
        next_ost_cnt = ost_cnt + OST_W'(1); // see RULE_08
      end
    end
    if (last) begin
      unique case (state)
        ST_RUN: begin
          next_ir = INSTR;
          next_pc = PC + PC_W'(1);
          if (irq_pend) begin
            next_irq_pend = 1'b0;
            next_state = ST_DUMMY1; // see RULE_11
          end else if (is_goto) begin
            next_pc = PC_W'({PC_PAGE, ir[LIT11_HI:0]}); // see RULE_06
            next_state = ST_FLUSH;
          end else if (is_ret) begin
            next_pc = STACK_TOP; // see RULE_06
            next_state = ST_FLUSH;
          end else if (is_skip && COND_TRUE) begin
            next_state = ST_FLUSH; // see RULE_06
          end else if (is_sleep) begin
            next_state = ST_SLEEP;
          end
        end
        ST_FLUSH: begin
          next_ir = INSTR;
          next_pc = PC + PC_W'(1);
          next_state = ST_RUN; // see RULE_12
        end
        ST_SLEEP: begin
          if (IRQ_WAKE) begin
            next_irq_pend = GLOBAL_IRQ_ENABLE; // see RULE_09
            next_ost_cnt = '0;
            next_state = crystal ? ST_OST : ST_RUN; // see RULE_08
          end
        end
        ST_OST: begin
          if (ost_cnt == OST_W'(OST_CYCLES)) begin
            next_state = ST_RUN; // see RULE_08
          end
        end
        ST_DUMMY1: begin
          next_pc = PC_W'(IRQ_VECTOR); // see RULE_09
          next_state = ST_DUMMY2;
        end
        ST_DUMMY2: begin
          next_ir = INSTR;
          next_pc = PC + PC_W'(1);
          next_state = ST_RUN; // see RULE_11
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_FLUSH;
      ir <= '0;
      PC <= PC_W'(PC_RESET);
      irq_pend <= 1'b0;
      ost_cnt <= '0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      PC <= next_pc;
      irq_pend <= next_irq_pend;
      ost_cnt <= next_ost_cnt;
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_phase_order;
    QUARTER == 4'h1 |=> QUARTER == 4'h2 ##1 QUARTER == 4'h4 ##1 QUARTER == 4'h8;
  endproperty
  a_phase_order: assert property (p_phase_order) // see RULE_07
    else $error("quarter phases out of order");

  property p_flush_quiet;
    state == ST_FLUSH || state == ST_DUMMY1 || state == ST_DUMMY2
      |-> !WR_W && !WR_FILE && !POP;
  endproperty
  a_flush_quiet: assert property (p_flush_quiet) // see RULE_12
    else $error("write during a dummy cycle");

  property p_skip_flush;
    run && last && !irq_pend && is_skip && COND_TRUE
      |=> state == ST_FLUSH [*4] ##1 state == ST_RUN;
  endproperty
  a_skip_flush: assert property (p_skip_flush) // see RULE_06
    else $error("skip did not add one nop cycle");

  property p_goto_target;
    run && last && !irq_pend && is_goto
      |=> PC == PC_W'({$past(PC_PAGE), $past(ir[10:0])});
  endproperty
  a_goto_target: assert property (p_goto_target) // see RULE_05
    else $error("jump target wrong");

  property p_dest_sel;
    WR_W && cls == CLS_BYTE |-> !ir[DEST_POS] && !WR_FILE;
  endproperty
  a_dest_sel: assert property (p_dest_sel) // see RULE_02
    else $error("byte result sent to wrong place");

  property p_rc_no_wait;
    state == ST_SLEEP && last && IRQ_WAKE && !crystal |=> state == ST_RUN;
  endproperty
  a_rc_no_wait: assert property (p_rc_no_wait) // see RULE_08
    else $error("resistor-capacitor wake inserted a delay");

  property p_ost_hold;
    state == ST_OST && ost_cnt < OST_W'(OST_CYCLES) |=> state == ST_OST;
  endproperty
  a_ost_hold: assert property (p_ost_hold) // see RULE_08
    else $error("start-up delay cut short");

  property p_vector;
    state == ST_DUMMY2 && last |=> run && PC == PC_W'(IRQ_VECTOR) + PC_W'(1);
  endproperty
  a_vector: assert property (p_vector) // see RULE_09
    else $error("vector fetch address wrong");

  property p_two_dummies;
    run && last && irq_pend |=> state == ST_DUMMY1 [*4] ##1 state == ST_DUMMY2;
  endproperty
  a_two_dummies: assert property (p_two_dummies) // see RULE_11
    else $error("wake did not insert two dummy cycles");

  property p_ext_clk;
    EXT_CLK_OK |-> OSC_MODE_SEL_HI && !OSC_MODE_SEL_LO;
  endproperty
  a_ext_clk: assert property (p_ext_clk) // see RULE_10
    else $error("external clock allowed outside high-speed mode");

  c_skip: cover property (run && last && is_skip && COND_TRUE);
  c_sleep: cover property (state == ST_SLEEP);
  c_ost_done: cover property (state == ST_OST ##1 run);
  c_vector: cover property (state == ST_DUMMY2 ##1 run);
endmodule : cis_sequencer
`default_nettype wire

// File: verification/cis_prog_mem.sv
/*
  program memory model: sixteen 14-bit words answered combinationally.
  assumes the bench fills every word before reset is released.
*/
`timescale 1ns/1ps
`default_nettype none
module cis_prog_mem
  import cis_pkg::*;
#(
  parameter int PC_W = 13
) (
  // fetch
  input wire logic [PC_W-1:0] PC,
  output logic [INSTR_W-1:0] INSTR
);
  logic [INSTR_W-1:0] mem [0:15];
  // whole words only; nothing stored past the image
  assign INSTR = (PC[PC_W-1:4] == '0) ? mem[PC[3:0]] : '0;
endmodule : cis_prog_mem
`default_nettype wire

// File: verification/core_instruction_sequencer_bench.sv
/*
  self-checking bench: program image, sleep and wake in two osc modes.
  assumes the sequencer and the program memory model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module core_instruction_sequencer_bench
  import cis_pkg::*;
;
  logic clk, rst_n, hi, lo, irq_en, irq, run, ew, ef, ep, skip;
  logic cond = 1'b0;
  logic [12:0] pc;
  logic [13:0] instr, w;
  logic [6:0] file_addr;
  logic [7:0] lit8;
  logic [10:0] lit11;
  logic [2:0] bit_sel;
  logic [1:0] op_class;
  logic [3:0] quarter;
  logic [3:0] qp = 4'h1;
  logic exec_valid, wr_w, wr_file, push, pop, sleeping, ext_ok;
  int err_count, total_checks, cyc, last, a, n, pushes;
  int exp_q[$];
  logic [31:0] r;

  cis_sequencer u_cis_sequencer (.CLK(clk), .RST_N(rst_n), .PC(pc),
    .INSTR(instr), .OSC_MODE_SEL_HI(hi), .OSC_MODE_SEL_LO(lo),
    .GLOBAL_IRQ_ENABLE(irq_en), .IRQ_WAKE(irq), .COND_TRUE(cond),
    .STACK_TOP(13'h0000), .PC_PAGE(2'h0), .OP_CLASS(op_class),
    .FILE_ADDR(file_addr), .BIT_SEL(bit_sel), .LITERAL8(lit8),
    .LITERAL11(lit11), .QUARTER(quarter),
    .EXEC_VALID(exec_valid), .WR_W(wr_w), .WR_FILE(wr_file), .PUSH(push),
    .POP(pop), .SLEEPING(sleeping), .EXT_CLK_OK(ext_ok));
  cis_prog_mem u_cis_prog_mem (.PC(pc), .INSTR(instr));

  task chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  // wait for the sleep flag to reach v, bounded
  task wait_sleep(input logic v, input int lim);
    n = 0;
    while (sleeping !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) begin
      err_count++;
      $display("unexpected at %0t: sleep flag wait ran out", $time);
      end_sim();
    end
  endtask : wait_sleep

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // reference model: order of executed words and their strobes
  always @(negedge clk) begin
    cyc++;
    cond = 1'($urandom);
    if (run) begin
      chk(quarter === {qp[2:0], qp[3]}, "phase order");
      if (exec_valid === 1'b1 && quarter === 4'h1) begin
        a = int'(pc) - 1;
        w = u_cis_prog_mem.mem[a[3:0]];
        chk(exp_q.size() > 0 && a == exp_q[0], "execution order");
        if (exp_q.size() > 0) void'(exp_q.pop_front());
        chk(file_addr === w[6:0] && lit8 === w[7:0], "fields");
        chk(op_class === w[13:12], "class field");
        chk(bit_sel === w[9:7], "bit field");
        chk(lit11 === w[10:0], "long literal field");
        if (a == 4 && pushes == 1) chk(cyc - last == 12, "dummies");
        last = cyc;
      end
      if (exec_valid === 1'b1 && quarter === 4'h8) begin
        ef = (w[13:12] == CLS_BYTE && w[7]) || (w[13:12] == CLS_BIT && !w[11]);
        ew = (w[13:12] == CLS_BYTE && !w[7] && w[11:8] != 4'h0) ||
             w[13:12] == CLS_LIT;
        chk(wr_w === ew && wr_file === ef, "write strobes");
        ep = w == OP_RETURN || w == OP_RETFIE ||
             (w[13:12] == CLS_LIT && w[11:10] == OP_RETLIT);
        chk(pop === ep, "return pop");
        skip = (w[13:12] == CLS_BYTE &&
                (w[11:8] == OP_DECFSZ || w[11:8] == OP_INCFSZ)) ||
               (w[13:12] == CLS_BIT && w[11]);
        if (skip && cond && exp_q.size() > 0) begin
          void'(exp_q.pop_front());
        end
      end
    end
    if (push === 1'b1) pushes++;
    qp = quarter;
  end

  initial begin
    rst_n = 1'b0;
    hi = 1'b0;
    lo = 1'b1;
    irq_en = 1'b1;
    irq = 1'b0;
    run = 1'b0;
    err_count = 0;
    total_checks = 0;
    void'($urandom(32'ha409));
    r = $urandom;
    for (int i = 0; i < 16; i++) u_cis_prog_mem.mem[i] = 14'h0000;
    u_cis_prog_mem.mem[0] = {7'h01, 7'h7f};
    u_cis_prog_mem.mem[1] = {2'h0, 4'h7, 1'b0, r[6:0]};
    u_cis_prog_mem.mem[2] = {CLS_BIT, OP_BSET, r[9:7], r[16:10]};
    u_cis_prog_mem.mem[3] = {3'h5, 11'h008};
    u_cis_prog_mem.mem[5] = {CLS_BYTE, OP_DECFSZ, 1'b1, 7'h20};
    u_cis_prog_mem.mem[7] = {CLS_BIT, OP_BTSTS, 3'h2, 7'h21};
    u_cis_prog_mem.mem[8] = {6'h30, r[24:17]};
    u_cis_prog_mem.mem[9] = OP_SLEEP;
    u_cis_prog_mem.mem[11] = {3'h5, 11'h00b};
    exp_q = '{0, 1, 2, 3, 8, 9, 10, 4, 5, 6, 7, 8, 9, 10, 11};
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    run = 1'b1;
    for (int m = 0; m < 4; m++) begin
      {hi, lo} = m[1:0];
      @(negedge clk);
      chk(ext_ok === (m == 2), "external clock permit");
    end
    {hi, lo} = standard_crystal_mode;
    wait_sleep(1'b1, 200);
    repeat (7) @(negedge clk);
    irq = 1'b1;
    wait_sleep(1'b0, 2000);
    chk(n >= 1024 && n <= 1036, "crystal start-up wait");
    irq = 1'b0;
    irq_en = 1'b0;
    {hi, lo} = resistor_capacitor_osc_mode;
    wait_sleep(1'b1, 400);
    repeat (3) @(negedge clk);
    irq = 1'b1;
    wait_sleep(1'b0, 2000);
    chk(n <= 5, "resistor-capacitor wake without wait");
    irq = 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(exp_q.size() == 0, "program did not finish");
    chk(pushes == 1, "vector entry only when enabled");
    end_sim();
  end
endmodule : core_instruction_sequencer_bench
`default_nettype wire
